// ===== rtl/gpib_dma_glue.sv
// cycle-steal dma glue between an instrument bus adapter and memory
// assumes: all pins synchronous to clk; registers over avalon-mm
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`include "gpib_dma_map.svh"
`default_nettype none

module gpib_dma_glue
  import gpib_dma_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        e_phase,
  input  wire logic        q_phase,
  input  wire logic        ba,
  input  wire logic        bs,
  input  wire logic        eoi_n,
  input  wire logic        own_talk_address,
  input  wire logic        own_listen_address,
  input  wire logic        untalk,
  input  wire logic        unlisten,
  input  wire logic        byte_event,
  input  wire logic        rlc_event,
  input  wire logic        serial_poll_active_flag_event,
  input  wire logic        other_cmd_event,
  output logic             cpu_bus_request_in_n,
  output logic             adapter_grant,
  output logic             dma_rw,
  output logic             dma_address_drive,
  output logic      [15:0] dma_address,
  output logic             adapter_irq
);
  byte_type   device_address_reg;
  byte_type   auxiliary_command_reg;
  byte_type   address_mode_reg;
  byte_type   address_status_reg;
  byte_type   int_mask;
  byte_type   int_status;
  byte_type   cmd_status;
  byte_type   dma_ctrl;
  word_type   dma_count;
  logic       byte_pending;
  logic       ack_busy;
  logic [3:0] ack_count;
  logic       e_prev;
  logic       eoi_prev;

  byte_type   next_device_address_reg;
  byte_type   next_auxiliary_command_reg;
  byte_type   next_address_mode_reg;
  byte_type   next_address_status_reg;
  byte_type   next_int_mask;
  byte_type   next_int_status;
  byte_type   next_cmd_status;
  byte_type   next_dma_ctrl;
  word_type   next_dma_address;
  word_type   next_dma_count;
  logic       next_byte_pending;
  logic       next_ack_busy;
  logic [3:0] next_ack_count;
  logic       next_irq;
  logic       next_wait;
  logic [31:0] next_readdata;

  logic [3:0] index;
  logic       soft_reset;
  logic       locked;
  logic       wr;
  logic       e_fall;
  logic       eoi_fall;
  logic       cmd_trigger;
  logic       talker;
  logic       listener;
  logic       adapter_req;
  logic       xfer_done;
  byte_type   enabled_now;
  byte_type   enabled_next;

  req_link_if link ();

  assign link.to_memory = ~dma_ctrl[`CTRL_FROM_MEM_BIT];
  assign adapter_req    = byte_pending & ~ack_busy & ~soft_reset;

  always_comb
  begin
    index       = address[5:2];
    soft_reset  = auxiliary_command_reg[`AUX_RESET_BIT];
    // mode through cmd status regs shut while in soft reset
    locked      = soft_reset && (index >= `REG_ADDR_MODE)
                  && (index <= `REG_CMD_STATUS);
    wr          = write & ~waitrequest & ~locked;
    e_fall      = e_prev & ~e_phase;
    eoi_fall    = eoi_prev & ~eoi_n;
    talker      = address_status_reg[`ST_TALKER_BIT];
    listener    = address_status_reg[`ST_LISTENER_BIT];
    // mode bit 7 limits cmd sources
    cmd_trigger = rlc_event | serial_poll_active_flag_event
                  | (other_cmd_event & ~address_mode_reg[`MODE_GATE_BIT]);

    next_device_address_reg    = device_address_reg;
    next_auxiliary_command_reg = auxiliary_command_reg;
    next_address_mode_reg      = address_mode_reg;
    next_int_mask              = int_mask;
    next_dma_ctrl              = dma_ctrl;
    next_dma_address           = dma_address;
    next_dma_count             = dma_count;
    next_int_status            = int_status;
    next_cmd_status            = cmd_status;
    next_address_status_reg    = address_status_reg;

    if (wr)
    begin
      unique case (index)
        `REG_DEVICE_ADDR: next_device_address_reg = writedata[7:0];
        `REG_AUX_CMD:     next_auxiliary_command_reg = writedata[7:0];
        `REG_ADDR_MODE:   next_address_mode_reg = writedata[7:0];
        `REG_INT_MASK:    next_int_mask = writedata[7:0];
        `REG_INT_STATUS:  next_int_status = int_status & ~writedata[7:0];
        `REG_CMD_STATUS:  next_cmd_status = cmd_status & ~writedata[7:0];
        `REG_DMA_CTRL:    next_dma_ctrl = writedata[7:0];
        `REG_DMA_ADDR:    next_dma_address = writedata[15:0];
        `REG_DMA_COUNT:   next_dma_count = writedata[15:0];
        default:          next_dma_ctrl = dma_ctrl;
      endcase
    end
    else if (xfer_done)
    begin
      next_dma_address = dma_address + 16'h0001;
      next_dma_count   = dma_count - 16'h0001;
    end

    // set wins over clear on every event flag
    if (!soft_reset)
    begin
      if (untalk)
        next_address_status_reg[`ST_TALKER_BIT] = 1'b0;
      if (own_talk_address)
        next_address_status_reg[`ST_TALKER_BIT] = 1'b1;
      if (unlisten)
        next_address_status_reg[`ST_LISTENER_BIT] = 1'b0;
      if (own_listen_address)
        next_address_status_reg[`ST_LISTENER_BIT] = 1'b1;
      if (eoi_fall && listener)
        next_int_status[`INT_END_BIT] = 1'b1;
      if (cmd_trigger)
        next_int_status[`INT_CMD_BIT] = 1'b1;
      if (rlc_event)
        next_cmd_status[`CMD_RLC_BIT] = 1'b1;
      if (serial_poll_active_flag_event)
        next_cmd_status[`CMD_SERIAL_POLL_ACTIVE_FLAG_BIT] = 1'b1;
      if (other_cmd_event)
        next_cmd_status[`CMD_OTHER_BIT] = 1'b1;
    end
    next_address_status_reg[`ST_ADDRESSED_BIT] =
      next_address_status_reg[`ST_TALKER_BIT]
      | next_address_status_reg[`ST_LISTENER_BIT];

    // edge of enabled status, so mask restore refires
    enabled_now  = int_status & int_mask & {8{int_mask[`INT_MASTER_BIT]}};
    enabled_next = next_int_status & next_int_mask
                   & {8{next_int_mask[`INT_MASTER_BIT]}};
    next_irq     = |(enabled_next & ~enabled_now);

    // entering talker leaves the output buffer empty: first request
    next_byte_pending = byte_pending;
    if (xfer_done)
      next_byte_pending = 1'b0;
    if (byte_event || (own_talk_address && !talker && !soft_reset))
      next_byte_pending = 1'b1;

    // acknowledge spans seven e cycles before next request
    next_ack_busy  = ack_busy;
    next_ack_count = ack_count;
    if (xfer_done)
    begin
      next_ack_busy  = 1'b1;
      next_ack_count = 4'h0;
    end
    else if (ack_busy && e_fall)
    begin
      next_ack_count = ack_count + 4'h1;
      if (next_ack_count == `ACK_E_CYCLES)
        next_ack_busy = 1'b0;
    end

    // one wait cycle per access; simple, costs one clock per transfer
    next_wait     = ~((read | write) & waitrequest);
    next_readdata = 32'h0000_0000;
    if (read && waitrequest && !locked)
    begin
      unique case (index)
        `REG_DEVICE_ADDR: next_readdata[7:0] = device_address_reg;
        `REG_AUX_CMD:     next_readdata[7:0] = auxiliary_command_reg;
        `REG_ADDR_MODE:   next_readdata[7:0] = address_mode_reg;
        `REG_ADDR_STATUS: next_readdata[7:0] = address_status_reg;
        `REG_INT_MASK:    next_readdata[7:0] = int_mask;
        `REG_INT_STATUS:  next_readdata[7:0] = int_status;
        `REG_CMD_STATUS:  next_readdata[7:0] = cmd_status;
        `REG_DMA_CTRL:    next_readdata[7:0] = dma_ctrl;
        `REG_DMA_ADDR:    next_readdata[15:0] = dma_address;
        `REG_DMA_COUNT:   next_readdata[15:0] = dma_count;
        default:          next_readdata = 32'h0000_0000;
      endcase
    end
  end

  // reset forces adapter and dma into reset state
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      device_address_reg    <= 8'h00;
      auxiliary_command_reg <= `AUX_CMD_RESET;
      address_mode_reg      <= 8'h00;
      address_status_reg    <= 8'h00;
      int_mask              <= 8'h00;
      int_status            <= 8'h00;
      cmd_status            <= 8'h00;
      dma_ctrl              <= 8'h00;
      dma_address           <= 16'h0000;
      dma_count             <= 16'h0000;
      byte_pending          <= 1'b0;
      ack_busy              <= 1'b0;
      ack_count             <= 4'h0;
      e_prev                <= 1'b0;
      eoi_prev              <= 1'b1;
      adapter_irq           <= 1'b0;
      waitrequest           <= 1'b1;
      readdata              <= 32'h0000_0000;
    end
    else
    begin
      device_address_reg    <= next_device_address_reg;
      auxiliary_command_reg <= next_auxiliary_command_reg;
      address_mode_reg      <= next_address_mode_reg;
      address_status_reg    <= next_address_status_reg;
      int_mask              <= next_int_mask;
      int_status            <= next_int_status;
      cmd_status            <= next_cmd_status;
      dma_ctrl              <= next_dma_ctrl;
      dma_address           <= next_dma_address;
      dma_count             <= next_dma_count;
      byte_pending          <= next_byte_pending;
      ack_busy              <= next_ack_busy;
      ack_count             <= next_ack_count;
      e_prev                <= e_phase;
      eoi_prev              <= eoi_n;
      adapter_irq           <= next_irq;
      waitrequest           <= next_wait;
      readdata              <= next_readdata;
    end
  end

  request_synchronizer u_sync (
    .clk                  (clk),
    .reset                (reset),
    .q_phase              (q_phase),
    .eoi_n                (eoi_n),
    .link                 (link.sync_side),
    .cpu_bus_request_in_n (cpu_bus_request_in_n)
  );

  dma_sequencer u_seq (
    .clk           (clk),
    .reset         (reset),
    .enable        (dma_ctrl[`CTRL_ENABLE_BIT]),
    .count_zero    (dma_count == 16'h0000),
    .adapter_req   (adapter_req),
    .ba            (ba),
    .bs            (bs),
    .e_phase       (e_phase),
    .link          (link.seq_side),
    .adapter_grant (adapter_grant),
    .dma_rw        (dma_rw),
    .address_drive (dma_address_drive),
    .xfer_done     (xfer_done)
  );

  chk_ack_spacing: assert property (@(posedge clk) disable iff (reset)
    xfer_done |=> !adapter_req [*7])
    else $error("adapter request during byte acknowledge");
  chk_talk_flag_set: assert property (@(posedge clk) disable iff (reset)
    (own_talk_address && !soft_reset)
      |=> address_status_reg[`ST_TALKER_BIT]
          && address_status_reg[`ST_ADDRESSED_BIT])
    else $error("talker flag not set on own talk address");
  chk_listen_flag_set: assert property (@(posedge clk) disable iff (reset)
    (own_listen_address && !soft_reset)
      |=> address_status_reg[`ST_LISTENER_BIT])
    else $error("listener flag not set on own listen address");
  chk_soft_reset_lock: assert property (@(posedge clk) disable iff (reset)
    (write && !waitrequest && soft_reset && index == `REG_ADDR_MODE)
      |=> address_mode_reg == $past(address_mode_reg))
    else $error("mode register written during soft reset");
  chk_reset_state: assert property (@(posedge clk)
    reset |=> auxiliary_command_reg == `AUX_CMD_RESET && !adapter_grant
              && cpu_bus_request_in_n && !dma_ctrl[`CTRL_ENABLE_BIT])
    else $error("reset did not restore adapter and dma state");
  chk_cmd_gate: assert property (@(posedge clk) disable iff (reset)
    (address_mode_reg[`MODE_GATE_BIT] && !rlc_event && !serial_poll_active_flag_event
      && !int_status[`INT_CMD_BIT]) |=> !int_status[`INT_CMD_BIT])
    else $error("cmd flag set by a masked command source");
  chk_irq_edge: assert property (@(posedge clk) disable iff (reset)
    adapter_irq |-> |(enabled_now & ~$past(enabled_now)))
    else $error("interrupt without a setting edge");
endmodule

`default_nettype wire

// ===== rtl/gpib_dma_map.svh
// register indices, field positions, reset values and counts of the glue
// assumes: included by bare name; byte address is four times the index
`ifndef GPIB_DMA_MAP_SVH
`define GPIB_DMA_MAP_SVH

`define REG_DEVICE_ADDR   4'h0
`define REG_AUX_CMD       4'h1
`define REG_ADDR_MODE     4'h2
`define REG_ADDR_STATUS   4'h3
`define REG_INT_MASK      4'h4
`define REG_INT_STATUS    4'h5
`define REG_CMD_STATUS    4'h6
`define REG_DMA_CTRL      4'h7
`define REG_DMA_ADDR      4'h8
`define REG_DMA_COUNT     4'h9

`define AUX_RESET_BIT     7
`define MODE_GATE_BIT     7
`define AUX_CMD_RESET     8'h80

`define ST_LISTENER_BIT   0
`define ST_TALKER_BIT     1
`define ST_ADDRESSED_BIT  2

`define INT_MASTER_BIT    7
`define INT_END_BIT       2
`define INT_CMD_BIT       1

`define CMD_RLC_BIT       0
`define CMD_SERIAL_POLL_ACTIVE_FLAG_BIT      1
`define CMD_OTHER_BIT     2

`define CTRL_ENABLE_BIT   0
`define CTRL_FROM_MEM_BIT 1

`define ACK_E_CYCLES      4'h7

`endif

// ===== rtl/gpib_dma_pkg.sv
// types shared by the cycle-steal glue modules
// assumes: compiled before every other design file
`default_nettype none

package gpib_dma_pkg;
  typedef logic [7:0]  byte_type;
  typedef logic [15:0] word_type;
  typedef enum logic [1:0] {
    SEQ_IDLE       = 2'b00,
    SEQ_WAIT_GRANT = 2'b01,
    SEQ_MOVE       = 2'b10,
    SEQ_GIVE_BACK  = 2'b11
  } seq_state_type;
endpackage

`default_nettype wire

// ===== rtl/req_link_if.sv
// request link between the dma sequencer and the request synchronizer
// assumes: instantiated inside the glue top, one clock domain
`default_nettype none

interface req_link_if;
  logic drq;
  logic to_memory;
  modport seq_side  (output drq, input to_memory);
  modport sync_side (input drq, input to_memory);
endinterface

`default_nettype wire

// ===== rtl/request_synchronizer.sv
// aligns the sequencer request to the q phase and gates it on eoi for transfers to memory
// assumes: q_phase and eoi_n are synchronous to clk
`default_nettype none

module request_synchronizer
  import gpib_dma_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  reset,
  input  wire logic  q_phase,
  input  wire logic  eoi_n,
  req_link_if.sync_side link,
  output logic       cpu_bus_request_in_n
);
  logic q_prev;
  logic next_q_prev;
  logic next_breq_n;
  logic eoi_gate;
  logic q_rise;

  always_comb
  begin
    next_q_prev = q_phase;
    q_rise      = q_phase & ~q_prev;
    eoi_gate    = link.to_memory & ~eoi_n;
    next_breq_n = cpu_bus_request_in_n;
    if (!link.drq || eoi_gate)
      next_breq_n = 1'b1;
    // assert on q rise, never late in e
    else if (q_rise)
      next_breq_n = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q_prev               <= 1'b0;
      cpu_bus_request_in_n <= 1'b1;
    end
    else
    begin
      q_prev               <= next_q_prev;
      cpu_bus_request_in_n <= next_breq_n;
    end
  end

  chk_breq_q_align: assert property (@(posedge clk) disable iff (reset)
    $fell(cpu_bus_request_in_n) |-> $past(q_phase) && !$past(q_prev))
    else $error("bus request rose outside a q rise");
  chk_eoi_blocks: assert property (@(posedge clk) disable iff (reset)
    (link.to_memory && !eoi_n) |=> cpu_bus_request_in_n)
    else $error("bus request passed while eoi asserted");
  chk_talk_ungated: assert property (@(posedge clk) disable iff (reset)
    (!link.to_memory && link.drq && q_phase && !q_prev)
      |=> !cpu_bus_request_in_n)
    else $error("outbound request lost to eoi gate");
  chk_breq_hold: assert property (@(posedge clk) disable iff (reset)
    (!cpu_bus_request_in_n && link.drq && !(link.to_memory && !eoi_n))
      |=> !cpu_bus_request_in_n)
    else $error("bus request dropped while still requested");
endmodule

`default_nettype wire

// ===== rtl/dma_sequencer.sv
// single channel cycle-steal sequencer: one byte per bus grant
// assumes: ba and bs come straight from the processor, synchronous
`default_nettype none

module dma_sequencer
  import gpib_dma_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  reset,
  input  wire logic  enable,
  input  wire logic  count_zero,
  input  wire logic  adapter_req,
  input  wire logic  ba,
  input  wire logic  bs,
  input  wire logic  e_phase,
  req_link_if.seq_side link,
  output logic       adapter_grant,
  output logic       dma_rw,
  output logic       address_drive,
  output logic       xfer_done
);
  seq_state_type state;
  seq_state_type next_state;
  logic          e_prev;
  logic          bus_granted;
  logic          next_drq;
  logic          next_grant;
  logic          next_done;

  always_comb
  begin
    bus_granted = ba & bs;
    next_state  = state;
    next_drq    = link.drq;
    next_grant  = adapter_grant;
    next_done   = 1'b0;
    unique case (state)
      SEQ_IDLE:
        if (adapter_req && enable && !count_zero)
        begin
          next_state = SEQ_WAIT_GRANT;
          next_drq   = 1'b1;
        end
      SEQ_WAIT_GRANT:
        if (!adapter_req || !enable)
        begin
          next_state = SEQ_IDLE;
          next_drq   = 1'b0;
        end
        else if (bus_granted)
        begin
          next_state = SEQ_MOVE;
          next_grant = 1'b1;
        end
      SEQ_MOVE:
        if (e_prev && !e_phase)
        begin
          next_state = SEQ_GIVE_BACK;
          next_grant = 1'b0;
          next_drq   = 1'b0;
          next_done  = 1'b1;
        end
      SEQ_GIVE_BACK:
        if (!bus_granted)
          next_state = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state         <= SEQ_IDLE;
      e_prev        <= 1'b0;
      link.drq      <= 1'b0;
      adapter_grant <= 1'b0;
      dma_rw        <= 1'b0;
      address_drive <= 1'b0;
      xfer_done     <= 1'b0;
    end
    else
    begin
      state         <= next_state;
      e_prev        <= e_phase;
      link.drq      <= next_drq;
      adapter_grant <= next_grant;
      // address and direction only, no data path here
      dma_rw        <= ~link.to_memory;
      address_drive <= next_grant;
      xfer_done     <= next_done;
    end
  end

  chk_grant_needs_bus: assert property (@(posedge clk) disable iff (reset)
    $rose(adapter_grant) |-> $past(ba && bs) && address_drive)
    else $error("grant raised without processor bus release");
  chk_bus_returned: assert property (@(posedge clk) disable iff (reset)
    $fell(adapter_grant) |-> !link.drq && xfer_done ##1 !adapter_grant)
    else $error("bus kept across byte boundary");
endmodule

`default_nettype wire

// ===== bench/cpu_bus_model.sv
// processor side: e/q quadrature phases and cycle-steal bus grant
// assumes: breq_n comes from the glue, one clock domain
`default_nettype none

module cpu_bus_model
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic breq_n,
  output logic      e_phase,
  output logic      q_phase,
  output logic      ba,
  output logic      bs
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] ph;

  // q leads e by a quarter of the eight-cycle e period
  assign e_phase = ph[2];
  assign q_phase = ph[2] ^ ph[1];

  always @(posedge clk)
  begin
    if (reset)
    begin
      ph <= 3'h0;
      ba <= 1'b0;
      bs <= 1'b0;
    end
    else
    begin
      ph <= ph + 3'h1;
      // grant only per e cycle, released once request drops
      if (ph == 3'h7)
      begin
        ba <= !breq_n;
        bs <= !breq_n;
      end
    end
  end
endmodule

`default_nettype wire

// ===== bench/test_gpib_cycle_steal_dma_glue.sv
// self-checking bench for the cycle-steal glue
// assumes: processor model drives e, q, ba and bs
`default_nettype none

module test_gpib_cycle_steal_dma_glue;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {logic [3:0] idx; logic [31:0] wd; logic [31:0] ex;} row_type;

  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [5:0]  address = 6'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        e_phase, q_phase, ba, bs;
  logic        eoi_n = 1'b1;
  logic [7:0]  evt = 8'h00;
  logic        breq_n, grant, rw, drive, irq;
  logic [15:0] dma_address;
  logic [2:0]  qh = 3'h0;
  logic        e_prev = 1'b0;
  int          ecnt = 0;
  int          num_errors = 0;
  int          tests_run = 0;
  row_type     rows[7];
  logic [31:0] v;
  int          e0;
  int          lows;
  int          gap;

  always #5 clk = ~clk;

  // q history and e falling edge count, seen as the glue sees them
  always @(posedge clk)
  begin
    qh <= {qh[1:0], q_phase};
    e_prev <= e_phase;
    if (e_prev && !e_phase)
      ecnt <= ecnt + 1;
  end

  cpu_bus_model i_cpu (.clk(clk), .reset(reset), .breq_n(breq_n),
    .e_phase(e_phase), .q_phase(q_phase), .ba(ba), .bs(bs));

  gpib_dma_glue i_dut (.clk(clk), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .e_phase(e_phase),
    .q_phase(q_phase), .ba(ba), .bs(bs), .eoi_n(eoi_n),
    .own_talk_address(evt[7]), .own_listen_address(evt[6]),
    .untalk(evt[5]), .unlisten(evt[4]), .byte_event(evt[3]),
    .rlc_event(evt[2]), .serial_poll_active_flag_event(evt[1]), .other_cmd_event(evt[0]),
    .cpu_bus_request_in_n(breq_n), .adapter_grant(grant), .dma_rw(rw),
    .dma_address_drive(drive), .dma_address(dma_address),
    .adapter_irq(irq));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] ex);
    tests_run++;
    if (seen !== ex)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, ex, seen);
    end
  endtask

  // one avalon access; held until waitrequest is low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    int i;
    @(posedge clk);
    address <= {idx, 2'b00};
    writedata <= wd;
    write <= wr;
    read <= !wr;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (waitrequest === 1'b0)
        break;
    end
    if (i == 50)
      wrap_up_timeout();
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic wrap_up_timeout();
    num_errors++;
    wrap_up();
  endtask

  task automatic pulse(input int n);
    @(posedge clk);
    evt <= 8'h01 << n;
    @(posedge clk);
    evt <= 8'h00;
  endtask

  function automatic logic sig(input int s);
    return (s == 0) ? breq_n : (s == 1) ? grant : irq;
  endfunction

  task automatic wait_sig(input int s, input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      @(negedge clk);
      if (sig(s) === lvl)
        return;
    end
    wrap_up_timeout();
  endtask

  // one byte moved by cycle steal, from request to bus give-back
  task automatic one_byte(input logic exp_rw);
    wait_sig(0, 1'b0, 300);
    gap = ecnt - e0;
    // q low four clocks: only the newest sample is high
    check("q_rise", {29'h0, qh}, 32'h1);
    wait_sig(1, 1'b1, 50);
    check("rw", rw, exp_rw);
    check("drive", drive, 1'b1);
    wait_sig(1, 1'b0, 50);
    e0 = ecnt;
    wait_sig(0, 1'b1, 5);
    @(posedge clk);
  endtask

  initial
  begin
    // mask 86: only end and cmd may interrupt
    rows = '{'{4'h0, 32'h5A, 32'h5A}, '{4'h2, 32'h80, 32'h80},
             '{4'h4, 32'h86, 32'h86}, '{4'h8, 32'h1000, 32'h1000},
             '{4'h9, 32'h10, 32'h10}, '{4'h3, 32'hFF, 32'h0},
             '{4'hC, 32'hFF, 32'h0}};
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check("breq_rst", breq_n, 1'b1);
    check("grant_rst", grant, 1'b0);
    check("addr_rst", dma_address, 16'h0);
    bus(1'b0, 4'h1, 32'h0, v);
    check("aux_rst", v, 32'h80);
    bus(1'b1, 4'h2, 32'h80, v);
    bus(1'b0, 4'h2, 32'h0, v);
    check("mode_locked", v, 32'h0);
    // init order: device address, aux zero, then mode
    bus(1'b1, 4'h0, 32'h3, v);
    bus(1'b1, 4'h1, 32'h0, v);
    bus(1'b1, 4'h2, 32'h0, v);
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].idx, rows[i].wd, v);
      bus(1'b0, rows[i].idx, 32'h0, v);
      check("reg_row", v, rows[i].ex);
    end
    pulse(0);
    bus(1'b0, 4'h5, 32'h0, v);
    check("cmd_gated", v, 32'h0);
    pulse(2);
    wait_sig(2, 1'b1, 10);
    bus(1'b0, 4'h5, 32'h0, v);
    check("cmd_set", v, 32'h2);
    pulse(1);
    bus(1'b0, 4'h6, 32'h0, v);
    check("cmd_status", v, 32'h7);
    pulse(6);
    bus(1'b0, 4'h3, 32'h0, v);
    check("listener", v & 32'h1, 32'h1);
    // dma enabled only once addressed, memory as target
    bus(1'b1, 4'h7, 32'h1, v);
    pulse(3);
    one_byte(1'b0);
    check("addr_inc", dma_address, 16'h1001);
    pulse(3);
    one_byte(1'b0);
    check("ack_gap", gap >= 7, 1'b1);
    eoi_n <= 1'b0;
    pulse(3);
    lows = 0;
    repeat (150)
    begin
      @(negedge clk);
      if (breq_n !== 1'b1)
        lows++;
    end
    check("eoi_gate", lows, 0);
    bus(1'b0, 4'h5, 32'h0, v);
    check("end_set", v & 32'h4, 32'h4);
    // mask cleared then restored fires on standing status
    bus(1'b1, 4'h4, 32'h0, v);
    bus(1'b1, 4'h4, 32'h86, v);
    wait_sig(2, 1'b1, 3);
    eoi_n <= 1'b1;
    one_byte(1'b0);
    bus(1'b1, 4'h7, 32'h3, v);
    eoi_n <= 1'b0;
    pulse(3);
    one_byte(1'b1);
    eoi_n <= 1'b1;
    pulse(4);
    bus(1'b0, 4'h3, 32'h0, v);
    check("unlisten", v & 32'h1, 32'h0);
    pulse(7);
    bus(1'b0, 4'h3, 32'h0, v);
    check("talker", v & 32'h2, 32'h2);
    pulse(5);
    bus(1'b0, 4'h3, 32'h0, v);
    check("untalk", v & 32'h2, 32'h0);
    wrap_up();
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    wrap_up_timeout();
  end
endmodule

`default_nettype wire
